/* rtl/gpr_defines.vh */
// Contract
// - Ports A-F each have an 8-bit R/W output latch resetting to zero.
// - Ports A-F each have an 8-bit R/W direction register resetting to inputs.
// - Ports A-F each have a read-only pin sample register; writes store nothing.
// - Port G output latch has bits 4..0 R/W reset zero; bits 7..5 read zero.
// - Port G direction has bits 4..0 R/W; bits 7..5 read zero.
// - In legacy mode every port C pin is a push-pull output driving zero; the code drives the port C latch value, which stays writable.
// - Pins take their reset state from reset alone, even with no clock.
// - Legacy mode hides port F latch and direction; port F is input only.
// - Legacy mode makes all port G registers unavailable.
`ifndef GPR_DEFINES_VH
`define GPR_DEFINES_VH

// Byte address = port index * PORT_STRIDE + register slot * 4
`define GPR_PORT_STRIDE 8'h10
`define GPR_SLOT_LATCH 2'h0
`define GPR_SLOT_DIR 2'h1
`define GPR_SLOT_SAMPLE 2'h2
`define GPR_NUM_PORTS 3'h7
`define GPR_IDX_C 3'h2
`define GPR_IDX_F 3'h5
`define GPR_IDX_G 3'h6
`define GPR_IDX_STATUS 3'h7
`define GPR_STATUS_ADDR 8'h70
`define GPR_STATUS_LEGACY_BIT 0
`define GPR_LATCH_RESET 8'h00
`define GPR_DIR_RESET 8'h00
`define GPR_PORT_WIDTH 8
`define GPR_PORT_G_WIDTH 5
`define GPR_RESP_OKAY 2'h0
`define GPR_RESP_SLVERR 2'h2

`endif

/* rtl/gpr_port.v */
`timescale 1ns/100ps
`include "gpr_defines.vh"

module gpr_port #(
  parameter WIDTH = `GPR_PORT_WIDTH
) (
  input wire ref_clk,
  input wire rstn,
  input wire wr_latch,
  input wire wr_dir,
  input wire [WIDTH-1:0] wdata,
  input wire [WIDTH-1:0] pin_in,
  output reg [WIDTH-1:0] latch,
  output reg [WIDTH-1:0] dir,
  output reg [WIDTH-1:0] sample
);

  reg [WIDTH-1:0] sync_meta;

  // Latch and direction; reset is asynchronous so pins settle without a clock
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      latch <= {WIDTH{1'b0}};
      dir <= {WIDTH{1'b0}};
    end else begin
      if (wr_latch) begin
        latch <= wdata;
      end
      if (wr_dir) begin
        dir <= wdata;
      end
    end
  end

  // Two-stage synchroniser; sample ignores direction, so outputs read back
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_meta <= {WIDTH{1'b0}};
      sample <= {WIDTH{1'b0}};
    end else begin
      sync_meta <= pin_in;
      sample <= sync_meta;
    end
  end

endmodule // gpr_port

/* rtl/gpr_top.v */
`timescale 1ns/100ps
`include "gpr_defines.vh"

module gpr_top (
  input wire ref_clk,
  input wire rstn,
  input wire legacy_mode,
  input wire [55:0] pin_in,
  output wire [55:0] pin_out,
  output wire [55:0] pin_oe,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  wire [55:0] lat_all;
  wire [55:0] dir_all;
  wire [55:0] smp_all;
  wire [6:0] wr_latch;
  wire [6:0] wr_dir;
  reg legacy_meta;
  reg legacy_q;
  reg aw_full;
  reg w_full;
  reg [7:0] aw_addr;
  reg [7:0] w_data;
  reg w_lane0;
  reg next_aw_full;
  reg next_w_full;
  reg next_bvalid;
  wire wr_fire;
  wire wr_ok;
  wire [2:0] wr_idx;
  wire [1:0] wr_slot;

  // Address decode shared by the write and read paths
  function addr_mapped;
    input [7:0] addr;
    begin
      if (addr[1:0] != 2'h0) begin
        addr_mapped = 1'b0;
      end else if (addr == `GPR_STATUS_ADDR) begin
        addr_mapped = 1'b1;
      end else begin
        addr_mapped = (addr[6:4] < `GPR_NUM_PORTS) && (addr[3:2] <= `GPR_SLOT_SAMPLE)
          && !addr[7];
      end
    end
  endfunction

  // Register hidden while legacy mode is on; access gives OKAY and zero
  function addr_hidden;
    input [7:0] addr;
    input legacy;
    begin
      addr_hidden = legacy && ((addr[6:4] == `GPR_IDX_G) ||
        ((addr[6:4] == `GPR_IDX_F) && (addr[3:2] != `GPR_SLOT_SAMPLE)));
    end
  endfunction

  // Read data for a mapped address
  function [7:0] read_value;
    input [7:0] addr;
    input legacy;
    input [55:0] lat;
    input [55:0] dir;
    input [55:0] smp;
    reg [5:0] base;
    begin
      base = {addr[6:4], 3'h0};
      if (addr == `GPR_STATUS_ADDR) begin
        read_value = 8'h00;
        read_value[`GPR_STATUS_LEGACY_BIT] = legacy;
      end else if (addr_hidden(addr, legacy)) begin
        read_value = 8'h00;
      end else if (addr[3:2] == `GPR_SLOT_LATCH) begin
        read_value = lat[base +: 8];
      end else if (addr[3:2] == `GPR_SLOT_DIR) begin
        read_value = dir[base +: 8];
      end else begin
        read_value = smp[base +: 8];
      end
    end
  endfunction

  // Mode strap is quasi-static, still synchronised before register gating
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      legacy_meta <= 1'b0;
      legacy_q <= 1'b0;
    end else begin
      legacy_meta <= legacy_mode;
      legacy_q <= legacy_meta;
    end
  end

  // Port slices; port G keeps only five bits
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_port
      localparam W = (gi == 6) ? `GPR_PORT_G_WIDTH : `GPR_PORT_WIDTH;
      gpr_port #(
        .WIDTH(W)
      ) u_port (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .wr_latch(wr_latch[gi]),
        .wr_dir(wr_dir[gi]),
        .wdata(w_data[W-1:0]),
        .pin_in(pin_in[gi*8 +: W]),
        .latch(lat_all[gi*8 +: W]),
        .dir(dir_all[gi*8 +: W]),
        .sample(smp_all[gi*8 +: W])
      );
      if (W < 8) begin : g_pad
        assign lat_all[gi*8+7:gi*8+W] = {(8-W){1'b0}};
        assign dir_all[gi*8+7:gi*8+W] = {(8-W){1'b0}};
        assign smp_all[gi*8+7:gi*8+W] = {(8-W){1'b0}};
      end
      assign wr_latch[gi] = wr_ok && (wr_idx == gi) && (wr_slot == `GPR_SLOT_LATCH);
      assign wr_dir[gi] = wr_ok && (wr_idx == gi) && (wr_slot == `GPR_SLOT_DIR);
    end
  endgenerate

  // Pin drive; hidden F and G registers stay at reset, so those pins stay inputs
  assign pin_out = lat_all; // port C latch resets to zero
  assign pin_oe[15:0] = dir_all[15:0];
  // Raw strap so port C drives during reset with no clock running
  assign pin_oe[23:16] = dir_all[23:16] | {8{legacy_mode}};
  // Raw strap keeps port F off the pins even if a direction bit was left set
  assign pin_oe[55:48] = dir_all[55:48];
  assign pin_oe[47:40] = dir_all[47:40] & {8{!legacy_mode}};
  assign pin_oe[39:24] = dir_all[39:24];

  // Write decode; sample slot and status have no storage behind them
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;
  assign wr_idx = aw_addr[6:4];
  assign wr_slot = aw_addr[3:2];
  assign wr_ok = wr_fire && w_lane0 && addr_mapped(aw_addr) && (wr_idx != `GPR_IDX_STATUS)
    && !addr_hidden(aw_addr, legacy_q);

  // Next state of the write channel holders
  always @* begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_bvalid = s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
    end
    if (wr_fire) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Write channels: address and data taken in either order, one write at a time
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GPR_RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_bvalid <= next_bvalid;
      s_axi_awready <= !next_aw_full && !next_bvalid;
      s_axi_wready <= !next_w_full && !next_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        s_axi_bresp <= addr_mapped(aw_addr) ? `GPR_RESP_OKAY : `GPR_RESP_SLVERR;
      end
    end
  end

  // Read channel: answer one cycle after the address is taken
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `GPR_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        if (addr_mapped(s_axi_araddr)) begin
          s_axi_rdata <= {24'h000000,
            read_value(s_axi_araddr, legacy_q, lat_all, dir_all, smp_all)};
          s_axi_rresp <= `GPR_RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `GPR_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1; // Comes up one cycle after reset release
      end
    end
  end

endmodule // gpr_top

/* tb/gpr_top_chk.sv */
`timescale 1ns/100ps
module gpr_top_chk (
  input wire ref_clk,
  input wire rstn,
  input wire legacy_mode,
  input wire [55:0] pin_out,
  input wire [55:0] pin_oe,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Request steps of the register bus
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_rd_answer: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  chk_b_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_r_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_rd_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_g_pins_off: assert property (pin_out[55:53] == 3'h0 && pin_oe[55:53] == 3'h0)
    else $error("absent port G pins active");
  chk_legacy_c_out: assert property (legacy_mode |-> pin_oe[23:16] == 8'hFF)
    else $error("legacy port C not driven");
  chk_legacy_f_in: assert property (legacy_mode |-> pin_oe[47:40] == 8'h00)
    else $error("legacy port F driven");
  // Pins must sit at their reset state while reset is low, clock or not
  chk_reset_pins: assert property (disable iff (1'b0)
    !rstn |-> pin_out == 56'h0 && pin_oe[15:0] == 16'h0 && pin_oe[55:24] == 32'h0)
    else $error("pins not in reset state");
endmodule // gpr_top_chk

bind gpr_top gpr_top_chk i_gpr_top_chk (.ref_clk(ref_clk), .rstn(rstn),
  .legacy_mode(legacy_mode), .pin_out(pin_out), .pin_oe(pin_oe), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* tb/gpr_top_tb_top.sv */
`timescale 1ns/100ps
module gpr_top_tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b1;
  logic legacy_mode = 1'b0;
  logic [55:0] pin_in = 56'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [55:0] pin_out, pin_oe;
  int num_errors = 0, num_checks = 0, cyc = 0, i;
  logic [7:0] lat [0:6];
  logic [7:0] dir [0:6];
  logic [7:0] odd [0:4] = '{8'h0C, 8'h71, 8'h74, 8'h80, 8'h02};
  gpr_top i_gpr_top (.ref_clk(ref_clk), .rstn(rstn), .legacy_mode(legacy_mode),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  always #5 ref_clk = ~ref_clk;
  // Hang guard, far above the few hundred cycles needed
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (num_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [55:0] exp, input logic [55:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // Address and data offered together; each dropped when its ready is seen
  task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic bad(input [7:0] a);
    return a[1:0] != 2'h0 || a[3:2] == 2'h3 || a > 8'h70;
  endfunction
  // Legacy hides port F latch and direction and all of port G
  function automatic logic hid(input [7:0] a);
    return legacy_mode && (a[7:4] == 4'h6 || (a[7:4] == 4'h5 && a[3:2] != 2'h2));
  endfunction
  function automatic logic [31:0] model(input [7:0] a);
    int p;
    p = a[7:4];
    if (bad(a) || hid(a)) return 32'h0;
    if (p == 7) return {31'h0, legacy_mode};
    if (a[3:2] == 2'h0) return {24'h0, lat[p]};
    if (a[3:2] == 2'h1) return {24'h0, dir[p]};
    return {24'h0, pin_in[8 * p +: 8] & (p == 6 ? 8'h1F : 8'hFF)};
  endfunction
  // One access checked against the model, response included
  task automatic acc(input logic w, input int ai, input [31:0] d);
    logic [31:0] got;
    logic [1:0] r;
    logic [7:0] a, m;
    int p;
    a = ai[7:0];
    p = a[7:4];
    m = (p == 6) ? 8'h1F : 8'hFF;
    if (w) begin
      wr(a, d, r);
      if (!bad(a) && !hid(a) && p < 7 && !a[3] && a[2]) dir[p] = d[7:0] & m;
      else if (!bad(a) && !hid(a) && p < 7 && !a[3]) lat[p] = d[7:0] & m;
    end else begin
      rd(a, got, r);
      cmp({24'h0, model(a)}, {24'h0, got});
    end
    cmp({54'h0, bad(a) ? 2'h2 : 2'h0}, {54'h0, r});
  endtask
  task automatic chk_pins();
    logic [55:0] eo, ee;
    for (int p = 0; p < 7; p++) begin
      eo[8 * p +: 8] = lat[p];
      ee[8 * p +: 8] = dir[p];
    end
    if (legacy_mode) ee[23:16] = 8'hFF;
    cmp(eo, pin_out);
    cmp(ee, pin_oe);
  endtask
  // Main sequence
  initial begin
    // Falling edge at time zero so the flops reset before the first clock
    rstn <= 1'b0;
    void'($urandom(32'hDA1A));
    for (i = 0; i < 7; i++) begin
      lat[i] = 8'h00;
      dir[i] = 8'h00;
    end
    @(negedge ref_clk);
    chk_pins();
    @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (i = 0; i < 7; i++) begin
      acc(0, 16 * i, 0);
      acc(0, 16 * i + 4, 0);
    end
    repeat (3) for (i = 0; i < 7; i++) begin
      acc(1, 16 * i, $urandom());
      acc(1, 16 * i + 4, $urandom());
      acc(0, 16 * i, 0);
      acc(0, 16 * i + 4, 0);
    end
    chk_pins();
    // Sampled levels ignore direction; writes there store nothing
    pin_in <= {$urandom(), 24'(($urandom()))};
    repeat (4) @(posedge ref_clk);
    for (i = 0; i < 7; i++) begin
      acc(1, 16 * i + 8, $urandom());
      acc(0, 16 * i + 8, 0);
    end
    for (i = 0; i < 5; i++) begin
      acc(1, odd[i], $urandom());
      acc(0, odd[i], 0);
    end
    // Status word: writes store nothing, legacy bit reads clear here
    acc(1, 8'h70, $urandom());
    acc(0, 8'h70, 0);
    // Legacy strap taken under a second reset
    rstn <= 1'b0;
    legacy_mode <= 1'b1;
    for (i = 0; i < 7; i++) begin
      lat[i] = 8'h00;
      dir[i] = 8'h00;
    end
    @(posedge ref_clk);
    chk_pins();
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // Port F and G latch, direction and sample accessed while legacy is on
    for (i = 5; i < 7; i++) begin
      acc(1, 16 * i, $urandom());
      acc(1, 16 * i + 4, $urandom());
      acc(0, 16 * i, 0);
      acc(0, 16 * i + 4, 0);
      acc(0, 16 * i + 8, 0);
    end
    acc(0, 8'h70, 0);
    chk_pins();
    report_and_stop();
  end
endmodule // gpr_top_tb_top
